// ==== inc/soc_defs.svh ====
`ifndef SOC_DEFS_SVH
`define SOC_DEFS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define SOC_ADDR_EXT_CTRL 8'hb1
`define SOC_ADDR_INT_CTRL 8'hb2
`define SOC_ADDR_INT_CAL 8'hb3

// ------------------------------------------------------------
// External oscillator control fields
// ------------------------------------------------------------
`define SOC_EXT_VALID_BIT 7
`define SOC_EXT_MODE_HI 6
`define SOC_EXT_MODE_LO 4
`define SOC_EXT_FREQ_HI 2
`define SOC_EXT_FREQ_LO 0
`define SOC_EXT_RESET 8'h00

// ------------------------------------------------------------
// Internal oscillator control fields
// ------------------------------------------------------------
`define SOC_INT_DIV_HI 1
`define SOC_INT_DIV_LO 0
`define SOC_INT_SSE_BIT 4
`define SOC_INT_SRC_BIT 7
`define SOC_DIV_RESET 2'h3
`define SOC_SSE_RESET 1'b0
`define SOC_SRC_RESET 1'b0

// ------------------------------------------------------------
// Calibration
// ------------------------------------------------------------
`define SOC_CAL_HI 6
`define SOC_CAL_LO 0
`define SOC_CAL_PLACEHOLDER 7'h40

// ------------------------------------------------------------
// Spread spectrum timing, in oscillator cycles
// ------------------------------------------------------------
`define SOC_SS_STEP_CYCLES 32
`define SOC_SS_PERIOD_CYCLES 384
`define SOC_SS_MAX_STEPS 3

`endif

// ==== inc/soc_pkg.sv ====
package soc_pkg;

	typedef enum logic [2:0] {
		SOC_EXT_OFF,
		SOC_EXT_CMOS,
		SOC_EXT_CMOS_DIV2,
		SOC_EXT_RC,
		SOC_EXT_CAP,
		SOC_EXT_XTAL,
		SOC_EXT_XTAL_DIV2
	} soc_ext_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} soc_sfr_req_t;

	typedef struct packed {
		soc_ext_mode_t mode;
		logic oscOn;
		logic div2;
		logic crystalMode;
		logic [2:0] freqCtrl;
	} soc_ext_ctrl_t;

endpackage

// ==== tb/soc_osc_ctrl_bench.sv ====
`timescale 1ns/1ps
module soc_osc_ctrl_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic xtalStable;
	soc_pkg::soc_sfr_req_t sfrReq = '0;
	logic [7:0] sfrRdata;
	logic [7:0] rdv;
	logic [6:0] oscTrim;
	logic signed [2:0] ssStep;
	logic ssStepStrobe;
	logic sysClkTick;
	logic clkSrcExternal;
	logic crystalValid;
	soc_pkg::soc_ext_ctrl_t extCtrl;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;

	soc_osc_ctrl soc_osc_ctrl_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .sfrReq(sfrReq),
		.sfrRdata(sfrRdata), .factoryTrim(7'h2a), .xtalStable(xtalStable), .oscTrim(oscTrim),
		.ssStep(ssStep), .ssStepStrobe(ssStepStrobe), .sysClkTick(sysClkTick),
		.clkSrcExternal(clkSrcExternal), .extCtrl(extCtrl), .crystalValid(crystalValid));
	soc_xtal_model #(.START_NS(500)) soc_xtal_model_i (.enable(extCtrl.crystalMode),
		.stable(xtalStable));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		if (num_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic reset();
		rst = 1'b1;
		tick(20);
		rst = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrReq.addr = a;
		sfrReq.wdata = d;
		sfrReq.wr = 1'b1;
		tick(1);
		sfrReq.wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a);
		sfrReq.addr = a;
		sfrReq.rd = 1'b1;
		tick(1);
		sfrReq.rd = 1'b0;
		tick(1);
		rdv = sfrRdata;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(clkSrcExternal, 8'h00);
		tick(3);
		check(oscTrim, 8'h2a);
		rd(8'hb2);
		check(rdv & 8'h83, 8'h03);
		rd(8'hb1);
		check(rdv, 8'h00);
		rd(8'hb3);
		check(rdv, 8'h2a);
	endtask
	task automatic t_div();
		int n;
		for (int d = 0; d < 4; d++) begin
			wr(8'hb2, 8'(d));
			n = 0;
			repeat (16) begin
				tick(1);
				n += sysClkTick;
			end
			check(8'(n), 8'(16 >> d));
		end
	endtask
	task automatic t_cal();
		wr(8'hb3, 8'hff);
		check(oscTrim, 8'h7f);
		rd(8'hb3);
		check(rdv, 8'h7f);
		wr(8'hb3, 8'h00);
		check(oscTrim, 8'h00);
		ce = 1'b0;
		wr(8'hb3, 8'h11);
		ce = 1'b1;
		tick(2);
		check(oscTrim, 8'h00);
	endtask
	task automatic t_ext();
		for (int c = 0; c < 8; c++) begin
			wr(8'hb1, {1'b1, 3'(c), 4'hd});
			rd(8'hb1);
			check(rdv & 8'h7f, {1'b0, 3'(c), 4'h5});
			check(extCtrl.mode, (c < 2) ? 8'h00 : 8'(c - 1));
			check(extCtrl.freqCtrl, 8'h05);
			check(extCtrl.div2, 8'(c == 3 || c == 7));
			check(extCtrl.oscOn, 8'(c >= 2));
		end
		tick(30);
		rd(8'hb1);
		check(rdv[7], 8'h01);
		check(crystalValid, 8'h01);
		wr(8'hb1, 8'h00);
		tick(4);
		check(crystalValid, 8'h00);
	endtask
	task automatic t_ss();
		logic [2:0] tri_seq [12] = '{1, 2, 3, 2, 1, 0, 7, 6, 5, 6, 7, 0};
		int n;
		wr(8'hb2, 8'h13);
		for (int i = 0; i < 12; i++) begin
			n = 0;
			while (!ssStepStrobe && n < 40) begin
				tick(1);
				n++;
			end
			check(unsigned'(ssStep), tri_seq[i]);
			if (i > 0) check(8'(n), 8'h1f);
			tick(1);
		end
		n = 0;
		while (!ssStepStrobe && n < 40) begin
			tick(1);
			n++;
		end
		check(unsigned'(ssStep), 8'h01);
		wr(8'hb2, 8'h03);
		check(unsigned'(ssStep), 8'h00);
	endtask
	task automatic t_src();
		wr(8'hb2, 8'h83);
		check(clkSrcExternal, 8'h01);
		reset();
		t_reset();
	endtask

	initial begin
		reset();
		t_reset();
		t_div();
		t_cal();
		t_ext();
		t_ss();
		t_src();
		conclude();
	end
endmodule // soc_osc_ctrl_bench

bind soc_osc_ctrl soc_osc_ctrl_monitor #(.CAL_DEFAULT(CAL_DEFAULT)) soc_osc_ctrl_monitor_i (
	.ref_clk(ref_clk), .rst(rst), .oscTrim(oscTrim), .ssStep(ssStep),
	.ssStepStrobe(ssStepStrobe), .sysClkTick(sysClkTick), .clkSrcExternal(clkSrcExternal),
	.extCtrl(extCtrl), .crystalValid(crystalValid));

// ==== tb/soc_osc_ctrl_monitor.sv ====
`timescale 1ns/1ps
module soc_osc_ctrl_monitor #(
	parameter logic [6:0] CAL_DEFAULT = 7'h40
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Watched outputs
	input wire logic [6:0] oscTrim,
	input wire logic signed [2:0] ssStep,
	input wire logic ssStepStrobe,
	input wire logic sysClkTick,
	input wire logic clkSrcExternal,
	input wire soc_pkg::soc_ext_ctrl_t extCtrl,
	input wire logic crystalValid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence quietSteps;
		!ssStepStrobe [*8];
	endsequence
	a_src_reset: assert property ($fell(rst) |-> !clkSrcExternal)
		else $error("clock source not internal after reset");
	a_tick_reset: assert property ($fell(rst) |-> !sysClkTick [*8])
		else $error("divider tick too early after reset");
	a_trim_reset: assert property ($fell(rst) |-> oscTrim == CAL_DEFAULT)
		else $error("trim not at default after reset");
	a_step_gap: assert property (ssStepStrobe |=> quietSteps)
		else $error("spread steps too close");
	a_step_unit: assert property (ssStepStrobe |-> ssStep - $past(ssStep) inside {1, -1})
		else $error("spread step not one unit");
	a_valid_mode: assert property (crystalValid |-> extCtrl.crystalMode
		|| $past(extCtrl.crystalMode))
		else $error("crystal valid outside crystal mode");
	a_xtal_mode: assert property (extCtrl.crystalMode == (extCtrl.mode
		inside {soc_pkg::SOC_EXT_XTAL, soc_pkg::SOC_EXT_XTAL_DIV2}))
		else $error("crystal mode flag wrong");
	a_div2_mode: assert property (extCtrl.div2 == (extCtrl.mode
		inside {soc_pkg::SOC_EXT_CMOS_DIV2, soc_pkg::SOC_EXT_XTAL_DIV2}))
		else $error("divide by two flag wrong");
	a_off_mode: assert property (extCtrl.oscOn == (extCtrl.mode != soc_pkg::SOC_EXT_OFF))
		else $error("oscillator on flag wrong");
endmodule // soc_osc_ctrl_monitor

// ==== tb/soc_xtal_model.sv ====
`timescale 1ns/1ps
module soc_xtal_model #(
	parameter int START_NS = 500
) (
	// Crystal drive and status
	input wire logic enable,
	output logic stable
);
	// Stable only after start-up time; drops at once when disabled
	always begin
		stable = 1'b0;
		wait (enable);
		#(START_NS);
		stable = enable;
		wait (!enable);
	end
endmodule // soc_xtal_model

// ==== verilog/soc_osc_ctrl.sv ====
`timescale 1ns/1ps
`include "soc_defs.svh"

module soc_osc_ctrl #(
	parameter logic [6:0] CAL_DEFAULT = `SOC_CAL_PLACEHOLDER
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Special function register port
	input wire soc_pkg::soc_sfr_req_t sfrReq,
	output logic [7:0] sfrRdata,
	// Factory trim and crystal status
	input wire logic [6:0] factoryTrim,
	input wire logic xtalStable,
	// Internal oscillator controls
	output logic [6:0] oscTrim,
	output logic signed [2:0] ssStep,
	output logic ssStepStrobe,
	output logic sysClkTick,
	output logic clkSrcExternal,
	// External oscillator controls
	output soc_pkg::soc_ext_ctrl_t extCtrl,
	output logic crystalValid
);

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic soc_pkg::soc_ext_mode_t modeOf(input logic [2:0] code);
		case (code)
			3'h2: modeOf = soc_pkg::SOC_EXT_CMOS;
			3'h3: modeOf = soc_pkg::SOC_EXT_CMOS_DIV2;
			3'h4: modeOf = soc_pkg::SOC_EXT_RC;
			3'h5: modeOf = soc_pkg::SOC_EXT_CAP;
			3'h6: modeOf = soc_pkg::SOC_EXT_XTAL;
			3'h7: modeOf = soc_pkg::SOC_EXT_XTAL_DIV2;
			default: modeOf = soc_pkg::SOC_EXT_OFF;
		endcase
	endfunction

	function automatic logic isCrystal(input soc_pkg::soc_ext_mode_t m);
		isCrystal = (m == soc_pkg::SOC_EXT_XTAL) || (m == soc_pkg::SOC_EXT_XTAL_DIV2);
	endfunction

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [2:0] extModeCode;
	logic [2:0] extFreq;
	logic [1:0] divSel;
	logic ssEnable;
	logic srcExternal;
	logic [6:0] cal;
	logic trimPending;
	logic xtalSync1;
	logic xtalSync2;
	logic [2:0] divCnt;

	// Whole-register reset image, sliced per field
	localparam logic [7:0] EXT_RESET = `SOC_EXT_RESET;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire hitExt = (sfrReq.addr == `SOC_ADDR_EXT_CTRL);
	wire hitInt = (sfrReq.addr == `SOC_ADDR_INT_CTRL);
	wire hitCal = (sfrReq.addr == `SOC_ADDR_INT_CAL);
	wire wrExt = sfrReq.wr && hitExt;
	wire wrInt = sfrReq.wr && hitInt;
	wire wrCal = sfrReq.wr && hitCal;

	wire soc_pkg::soc_ext_mode_t curMode = modeOf(extModeCode);
	wire next_valid = xtalSync2 && isCrystal(curMode);

	wire [7:0] extReadVal = {
		next_valid,
		extModeCode,
		1'b0,
		extFreq
	};
	wire [7:0] intReadVal = {
		srcExternal,
		2'b00,
		ssEnable,
		2'b00,
		divSel
	};
	wire [7:0] calReadVal = {1'b0, cal};
	wire [7:0] next_rdata = hitExt ? extReadVal :
		hitInt ? intReadVal :
		hitCal ? calReadVal : 8'h00;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// Ratio minus one, so that the count ends at the terminal value
	wire [2:0] divLast = 3'((4'h1 << divSel) - 4'h1);
	wire divDone = (divCnt >= divLast);
	wire [2:0] next_divCnt = divDone ? 3'h0 : divCnt + 3'h1;

	// ------------------------------------------------------------
	// External oscillator control
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extModeCode <= EXT_RESET[`SOC_EXT_MODE_HI:`SOC_EXT_MODE_LO];
			extFreq <= EXT_RESET[`SOC_EXT_FREQ_HI:`SOC_EXT_FREQ_LO];
		end else if (ce && wrExt) begin
			extModeCode <= sfrReq.wdata[`SOC_EXT_MODE_HI:`SOC_EXT_MODE_LO];
			extFreq <= sfrReq.wdata[`SOC_EXT_FREQ_HI:`SOC_EXT_FREQ_LO];
		end
	end

	// ------------------------------------------------------------
	// Internal oscillator control
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			divSel <= `SOC_DIV_RESET;
			ssEnable <= `SOC_SSE_RESET;
			srcExternal <= `SOC_SRC_RESET;
		end else if (ce && wrInt) begin
			divSel <= sfrReq.wdata[`SOC_INT_DIV_HI:`SOC_INT_DIV_LO];
			ssEnable <= sfrReq.wdata[`SOC_INT_SSE_BIT];
			srcExternal <= sfrReq.wdata[`SOC_INT_SRC_BIT];
		end
	end

	// ------------------------------------------------------------
	// Calibration
	// ------------------------------------------------------------
	// Factory trim is taken on the first enabled edge after reset release, unless a calibration write lands on that edge and wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cal <= CAL_DEFAULT;
			trimPending <= 1'b1;
		end else if (ce) begin
			if (wrCal) begin
				cal <= sfrReq.wdata[`SOC_CAL_HI:`SOC_CAL_LO];
				trimPending <= 1'b0;
			end else if (trimPending) begin
				cal <= factoryTrim;
				trimPending <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Crystal status synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			xtalSync1 <= 1'b0;
			xtalSync2 <= 1'b0;
		end else if (ce) begin
			xtalSync1 <= xtalStable;
			xtalSync2 <= xtalSync1;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			divCnt <= 3'h0;
			sysClkTick <= 1'b0;
			sfrRdata <= 8'h00;
			oscTrim <= CAL_DEFAULT;
			clkSrcExternal <= `SOC_SRC_RESET;
			crystalValid <= 1'b0;
			extCtrl <= '0;
		end else if (ce) begin
			divCnt <= next_divCnt;
			sysClkTick <= divDone;
			if (sfrReq.rd)
				sfrRdata <= next_rdata;
			oscTrim <= cal;
			clkSrcExternal <= srcExternal;
			crystalValid <= next_valid;
			extCtrl.mode <= curMode;
			extCtrl.oscOn <= (curMode != soc_pkg::SOC_EXT_OFF);
			extCtrl.div2 <= (curMode == soc_pkg::SOC_EXT_CMOS_DIV2) ||
				(curMode == soc_pkg::SOC_EXT_XTAL_DIV2);
			extCtrl.crystalMode <= isCrystal(curMode);
			extCtrl.freqCtrl <= extFreq;
		end
	end

	// ------------------------------------------------------------
	// Spread spectrum modulation
	// ------------------------------------------------------------
	soc_ss_tri #(
		.STEP_CYCLES(`SOC_SS_STEP_CYCLES),
		.PERIOD_CYCLES(`SOC_SS_PERIOD_CYCLES),
		.MAX_STEPS(`SOC_SS_MAX_STEPS)
	) ssTri (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.enable(ssEnable),
		.step(ssStep),
		.stepStrobe(ssStepStrobe)
	);

endmodule // soc_osc_ctrl

// ==== verilog/soc_ss_tri.sv ====
`timescale 1ns/1ps
`include "soc_defs.svh"

module soc_ss_tri #(
	parameter int STEP_CYCLES = `SOC_SS_STEP_CYCLES,
	parameter int PERIOD_CYCLES = `SOC_SS_PERIOD_CYCLES,
	parameter int MAX_STEPS = `SOC_SS_MAX_STEPS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Control
	input wire logic enable,
	// Modulation
	output logic signed [2:0] step,
	output logic stepStrobe
);

	localparam int PHASES = PERIOD_CYCLES / STEP_CYCLES;

	logic [4:0] cycleCnt;
	logic [3:0] phase;

	// Stepped triangle: 0 up to +MAX, down to -MAX, back up to 0
	function automatic logic signed [2:0] triOf(input logic [3:0] p);
		int v;
		v = int'(p);
		if (v <= MAX_STEPS)
			triOf = 3'(v);
		else if (v <= 3 * MAX_STEPS)
			triOf = 3'(2 * MAX_STEPS - v);
		else
			triOf = 3'(v - 4 * MAX_STEPS);
	endfunction

	wire stepDue = (cycleCnt == 5'(STEP_CYCLES - 1));
	wire lastPhase = (phase == 4'(PHASES - 1));
	wire [3:0] next_phase = lastPhase ? 4'h0 : phase + 4'h1;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cycleCnt <= 5'h0;
			phase <= 4'h0;
			step <= 3'sh0;
			stepStrobe <= 1'b0;
		end else if (ce) begin
			if (!enable) begin
				cycleCnt <= 5'h0;
				phase <= 4'h0;
				step <= 3'sh0;
				stepStrobe <= 1'b0;
			end else begin
				cycleCnt <= stepDue ? 5'h0 : cycleCnt + 5'h1;
				stepStrobe <= stepDue;
				if (stepDue) begin
					phase <= next_phase;
					step <= triOf(next_phase);
				end
			end
		end
	end

endmodule // soc_ss_tri
